// ===== src/rtcalm_defs.vh
`ifndef RTCALM_DEFS_VH
`define RTCALM_DEFS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define RTCALM_IDX_MTHDY   3'h0
`define RTCALM_IDX_WDHR    3'h1
`define RTCALM_IDX_MINSEC  3'h2
`define RTCALM_IDX_CTRL    3'h3
`define RTCALM_IDX_SETTLE  3'h4
`define RTCALM_IDX_STATUS  3'h5

// ----------------------------------------------------------------
// alarm field positions (lsb)
// ----------------------------------------------------------------
`define RTCALM_POS_MTH_TEN 12
`define RTCALM_POS_MTH_ONE 8
`define RTCALM_POS_DAY_TEN 4
`define RTCALM_POS_DAY_ONE 0
`define RTCALM_POS_WEEKDAY_VALUE    8
`define RTCALM_POS_HR_TEN  4
`define RTCALM_POS_HR_ONE  0
`define RTCALM_POS_MIN_TEN 12
`define RTCALM_POS_MIN_ONE 8
`define RTCALM_POS_SEC_TEN 4
`define RTCALM_POS_SEC_ONE 0

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define RTCALM_CTL_UNLOCK  0
`define RTCALM_CTL_CALEN   1
`define RTCALM_CTL_POWER_CTL_ENABLE   2
`define RTCALM_CTL_PINOE   3
`define RTCALM_CTL_SRC     4
`define RTCALM_CTL_POL     6
`define RTCALM_CTL_REPEAT  7
`define RTCALM_CTL_MASK    8
`define RTCALM_CTL_ALMEN   12
`define RTCALM_SRC_PWC     2'h3

// ----------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------
`define RTCALM_STS_STATE   0
`define RTCALM_STS_WAKE    2
`define RTCALM_STS_ALMEN   3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTCALM_RST_CTRL    13'h0000
`define RTCALM_RST_SETTLE  16'h0010

// ----------------------------------------------------------------
// repeat mask codes
// ----------------------------------------------------------------
`define RTCALM_MSK_HALFSEC 4'h0
`define RTCALM_MSK_SEC     4'h1
`define RTCALM_MSK_10SEC   4'h2
`define RTCALM_MSK_MIN     4'h3
`define RTCALM_MSK_10MIN   4'h4
`define RTCALM_MSK_HOUR    4'h5
`define RTCALM_MSK_DAY     4'h6
`define RTCALM_MSK_WEEK    4'h7
`define RTCALM_MSK_MONTH   4'h8
`define RTCALM_MSK_YEAR    4'h9

`endif

// ===== src/rtcalm_match.v
`timescale 1ns/1ps
`include "rtcalm_defs.vh"

module rtcalm_match (
    input wire [3:0] mask,       // repeat mask
    input wire [31:0] cur_flds,  // current fields, packed
    input wire [31:0] alm_flds,  // alarm fields, packed
    output reg match             // compared fields all equal
);

    // nibbles: sec1 sec10 min1 min10 hr1 hr10 weekday_value day1
    wire [7:0] eq;

    // ----------------------------------------------------------------
    // per-field equality
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_eq
            assign eq[gi] = (cur_flds[gi*4 +: 4] == alm_flds[gi*4 +: 4]);
        end
    endgenerate

    always @* begin
        case (mask)
            `RTCALM_MSK_HALFSEC: match = 1'b1;
            `RTCALM_MSK_SEC: match = 1'b1;
            `RTCALM_MSK_10SEC: match = eq[0];
            `RTCALM_MSK_MIN: match = &eq[1:0];
            `RTCALM_MSK_10MIN: match = &eq[2:0];
            `RTCALM_MSK_HOUR: match = &eq[3:0];
            `RTCALM_MSK_DAY: match = &eq[5:0];
            `RTCALM_MSK_WEEK: match = &eq[6:0];
            `RTCALM_MSK_MONTH: match = (&eq[5:0]) & eq[7];
            `RTCALM_MSK_YEAR: match = (&eq[5:0]) & eq[7];
            default: match = 1'b0;
        endcase
    end

endmodule // rtcalm_match

// ===== src/rtcalm_top.v
`timescale 1ns/1ps
`include "rtcalm_defs.vh"

// Function
// RULE1: month tens is one bit 0..1, month ones a four-bit BCD digit.
// RULE2: day tens is two bits 0..3, day ones a four-bit BCD digit.
// RULE3: month/day and weekday/hour writes only land while write unlock is set.
// RULE4: weekday is three bits in the upper byte, values 0..6.
// RULE5: hour tens is two bits 0..2, hour ones a four-bit BCD digit.
// RULE6: minute tens is three bits 0..5 upper byte, minute ones four bits.
// RULE7: second tens is three bits 0..5, second ones in the low nibble.
// RULE8: unimplemented alarm bits read zero; alarm fields are not reset.
// RULE9: repeat mask picks alarm interval from half a second up to yearly; code 0 fires once a second, as code 1 does.
// RULE10: power control switches device on, waits, samples wake, switches off.
// RULE11: power control runs only with calendar, enable, pin enable, source 11.
// RULE12: polarity bit picks active-low or active-high pin level.
// RULE13: software should set repeat forever so the power cycle recurs.
// RULE14: alarm fires when all fields left compared by the mask match; the code never fires a yearly alarm set to Feb 29.

module rtcalm_top (
    input wire ref_clk,                 // 100 MHz clock
    input wire rst_n,                   // synchronous reset, low active
    input wire [2:0] reg_addr,          // register index
    input wire [15:0] reg_wdata,        // write data
    input wire reg_wr,                  // write strobe
    input wire reg_rd,                  // read strobe
    output wire [15:0] reg_rdata,       // read data, cycle after strobe
    input wire sec_tick,                // one-cycle pulse per second
    input wire cur_month_tens_digit,    // current month tens
    input wire [3:0] cur_month_ones_digit, // current month ones
    input wire [1:0] cur_day_tens_digit,   // current day tens
    input wire [3:0] cur_day_ones_digit,   // current day ones
    input wire [2:0] cur_weekday_value,    // current weekday
    input wire [1:0] cur_hour_tens_digit,  // current hour tens
    input wire [3:0] cur_hour_ones_digit,  // current hour ones
    input wire [2:0] cur_minute_tens_digit, // current minute tens
    input wire [3:0] cur_minute_ones_digit, // current minute ones
    input wire [2:0] cur_second_tens_digit, // current second tens
    input wire [3:0] cur_second_ones_digit, // current second ones
    input wire wake_in,                 // wake request pin from device
    output wire alarm_event,            // one-cycle alarm pulse
    output wire wake_event,             // one-cycle sampled wake pulse
    output wire power_ctl_signal_out,   // pin level
    output wire power_ctl_signal_oe     // pin driven
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_SAMPLE = 2'h2;

    // ----------------------------------------------------------------
    // decode helper
    // ----------------------------------------------------------------
    function hit;
        input [2:0] addr;
        input [2:0] idx;
        begin
            hit = (addr == idx);
        end
    endfunction

    // ----------------------------------------------------------------
    // alarm field storage (no reset)
    // ----------------------------------------------------------------
    reg month_tens_digit_ff;
    reg [3:0] month_ones_digit_ff;
    reg [1:0] day_tens_digit_ff;
    reg [3:0] day_ones_digit_ff;
    reg [2:0] weekday_value_ff;
    reg [1:0] hour_tens_digit_ff;
    reg [3:0] hour_ones_digit_ff;
    reg [2:0] minute_tens_digit_ff;
    reg [3:0] minute_ones_digit_ff;
    reg [2:0] second_tens_digit_ff;
    reg [3:0] second_ones_digit_ff;

    // ----------------------------------------------------------------
    // control and status storage
    // ----------------------------------------------------------------
    reg [12:0] ctrl_ff;
    reg [12:0] nxt_ctrl;
    reg [15:0] settle_ff;
    reg [15:0] rdata_ff;
    reg [15:0] nxt_rdata;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [15:0] wait_ff;
    reg [15:0] nxt_wait;
    reg wake_seen_ff;
    reg nxt_wake_seen;
    reg alarm_ev_ff;
    reg wake_ev_ff;
    reg nxt_wake_ev;
    reg wake_meta_ff;
    reg wake_sync_ff;

    wire write_unlock;
    wire calendar_enable;
    wire power_ctl_enable;
    wire pin_output_enable;
    wire [1:0] pin_source_select;
    wire power_ctl_polarity;
    wire repeat_forever;
    wire [3:0] alarm_repeat_mask;
    wire alarm_enable;
    wire pwc_active;
    wire fld_match;
    wire feb29;
    wire fire;
    wire pwc_on;
    wire wr_mthdy;
    wire wr_wdhr;
    wire wr_minsec;
    wire [31:0] cur_flds;
    wire [31:0] alm_flds;

    assign write_unlock = ctrl_ff[`RTCALM_CTL_UNLOCK];
    assign calendar_enable = ctrl_ff[`RTCALM_CTL_CALEN];
    assign power_ctl_enable = ctrl_ff[`RTCALM_CTL_POWER_CTL_ENABLE];
    assign pin_output_enable = ctrl_ff[`RTCALM_CTL_PINOE];
    assign pin_source_select = ctrl_ff[`RTCALM_CTL_SRC +: 2];
    assign power_ctl_polarity = ctrl_ff[`RTCALM_CTL_POL];
    assign repeat_forever = ctrl_ff[`RTCALM_CTL_REPEAT];
    assign alarm_repeat_mask = ctrl_ff[`RTCALM_CTL_MASK +: 4];
    assign alarm_enable = ctrl_ff[`RTCALM_CTL_ALMEN];

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wr_mthdy = reg_wr & hit(reg_addr, `RTCALM_IDX_MTHDY) & write_unlock; // RULE3
    assign wr_wdhr = reg_wr & hit(reg_addr, `RTCALM_IDX_WDHR) & write_unlock; // RULE3
    assign wr_minsec = reg_wr & hit(reg_addr, `RTCALM_IDX_MINSEC);

    always @(posedge ref_clk) begin
        if (wr_mthdy) begin
            month_tens_digit_ff <= reg_wdata[`RTCALM_POS_MTH_TEN]; // RULE1
            month_ones_digit_ff <= reg_wdata[`RTCALM_POS_MTH_ONE +: 4]; // RULE1
            day_tens_digit_ff <= reg_wdata[`RTCALM_POS_DAY_TEN +: 2]; // RULE2
            day_ones_digit_ff <= reg_wdata[`RTCALM_POS_DAY_ONE +: 4]; // RULE2
        end
    end

    always @(posedge ref_clk) begin
        if (wr_wdhr) begin
            weekday_value_ff <= reg_wdata[`RTCALM_POS_WEEKDAY_VALUE +: 3]; // RULE4
            hour_tens_digit_ff <= reg_wdata[`RTCALM_POS_HR_TEN +: 2]; // RULE5
            hour_ones_digit_ff <= reg_wdata[`RTCALM_POS_HR_ONE +: 4]; // RULE5
        end
    end

    always @(posedge ref_clk) begin
        if (wr_minsec) begin
            minute_tens_digit_ff <= reg_wdata[`RTCALM_POS_MIN_TEN +: 3]; // RULE6
            minute_ones_digit_ff <= reg_wdata[`RTCALM_POS_MIN_ONE +: 4]; // RULE6
            second_tens_digit_ff <= reg_wdata[`RTCALM_POS_SEC_TEN +: 3]; // RULE7
            second_ones_digit_ff <= reg_wdata[`RTCALM_POS_SEC_ONE +: 4]; // RULE7
        end
    end

    // ----------------------------------------------------------------
    // settle time register
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            settle_ff <= `RTCALM_RST_SETTLE;
        end else if (reg_wr & hit(reg_addr, `RTCALM_IDX_SETTLE)) begin
            settle_ff <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // control register; one-shot alarm disarms itself
    // ----------------------------------------------------------------
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (fire & !repeat_forever) begin
            nxt_ctrl[`RTCALM_CTL_ALMEN] = 1'b0;
        end
        if (reg_wr & hit(reg_addr, `RTCALM_IDX_CTRL)) begin
            nxt_ctrl = reg_wdata[12:0];
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_ff <= `RTCALM_RST_CTRL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ----------------------------------------------------------------
    // alarm compare
    // ----------------------------------------------------------------
    assign cur_flds = {cur_day_ones_digit, 1'b0, cur_weekday_value, 2'h0,
                       cur_hour_tens_digit, cur_hour_ones_digit, 1'b0, cur_minute_tens_digit,
                       cur_minute_ones_digit, 1'b0, cur_second_tens_digit,
                       cur_second_ones_digit};
    assign alm_flds = {day_ones_digit_ff, 1'b0, weekday_value_ff, 2'h0,
                       hour_tens_digit_ff, hour_ones_digit_ff, 1'b0, minute_tens_digit_ff,
                       minute_ones_digit_ff, 1'b0, second_tens_digit_ff,
                       second_ones_digit_ff};

    wire mask_match;
    wire day_eq;
    wire month_eq;

    rtcalm_match u_match (
        .mask(alarm_repeat_mask),
        .cur_flds(cur_flds),
        .alm_flds(alm_flds),
        .match(mask_match)
    );

    assign day_eq = (cur_day_tens_digit == day_tens_digit_ff) & (cur_day_ones_digit == day_ones_digit_ff);
    assign month_eq = (cur_month_tens_digit == month_tens_digit_ff) &
                      (cur_month_ones_digit == month_ones_digit_ff);
    assign feb29 = !month_tens_digit_ff & (month_ones_digit_ff == 4'h2) &
                   (day_tens_digit_ff == 2'h2) & (day_ones_digit_ff == 4'h9);

    // day tens and month digits are compared here
    assign fld_match = (alarm_repeat_mask == `RTCALM_MSK_MONTH) ? (mask_match & day_eq) :
                       (alarm_repeat_mask == `RTCALM_MSK_YEAR) ?
                       mask_match & day_eq & month_eq & !feb29 :
                       mask_match; // RULE9 RULE14

    assign fire = sec_tick & calendar_enable & alarm_enable & fld_match; // RULE14

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            alarm_ev_ff <= 1'b0;
        end else begin
            alarm_ev_ff <= fire;
        end
    end

    // ----------------------------------------------------------------
    // wake pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
        end else begin
            wake_meta_ff <= wake_in;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // power control sequencer
    // ----------------------------------------------------------------
    assign pwc_active = calendar_enable & power_ctl_enable & pin_output_enable &
                        (pin_source_select == `RTCALM_SRC_PWC); // RULE11

    always @* begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_wake_ev = 1'b0;
        nxt_wake_seen = wake_seen_ff;
        if (reg_wr & hit(reg_addr, `RTCALM_IDX_STATUS) & reg_wdata[`RTCALM_STS_WAKE]) begin
            nxt_wake_seen = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (fire & pwc_active) begin
                    nxt_state = ST_SETTLE; // RULE10
                    nxt_wait = settle_ff;
                end
            end
            ST_SETTLE: begin
                if (!pwc_active) begin
                    nxt_state = ST_IDLE;
                end else if (wait_ff == 16'h0000) begin
                    nxt_state = ST_SAMPLE; // RULE10
                end else begin
                    nxt_wait = wait_ff - 16'h0001;
                end
            end
            ST_SAMPLE: begin
                nxt_wake_ev = wake_sync_ff & pwc_active; // RULE10
                if (wake_sync_ff & pwc_active) begin
                    nxt_wake_seen = 1'b1;
                end
                nxt_state = ST_IDLE; // RULE10
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            wait_ff <= 16'h0000;
            wake_ev_ff <= 1'b0;
            wake_seen_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            wake_ev_ff <= nxt_wake_ev;
            wake_seen_ff <= nxt_wake_seen;
        end
    end

    assign pwc_on = (state_ff != ST_IDLE) & pwc_active; // RULE11
    assign power_ctl_signal_out = power_ctl_polarity ? pwc_on : !pwc_on; // RULE12
    assign power_ctl_signal_oe = pwc_active;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always @* begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `RTCALM_IDX_MTHDY: begin
                    nxt_rdata = {3'h0, month_tens_digit_ff, month_ones_digit_ff, 2'h0,
                                 day_tens_digit_ff, day_ones_digit_ff}; // RULE8
                end
                `RTCALM_IDX_WDHR: begin
                    nxt_rdata = {5'h00, weekday_value_ff, 2'h0, hour_tens_digit_ff,
                                 hour_ones_digit_ff}; // RULE8
                end
                `RTCALM_IDX_MINSEC: begin
                    nxt_rdata = {1'b0, minute_tens_digit_ff, minute_ones_digit_ff, 1'b0,
                                 second_tens_digit_ff, second_ones_digit_ff}; // RULE8
                end
                `RTCALM_IDX_CTRL: begin
                    nxt_rdata = {3'h0, ctrl_ff};
                end
                `RTCALM_IDX_SETTLE: begin
                    nxt_rdata = settle_ff;
                end
                `RTCALM_IDX_STATUS: begin
                    nxt_rdata = {12'h000, alarm_enable, wake_seen_ff, state_ff};
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign alarm_event = alarm_ev_ff;
    assign wake_event = wake_ev_ff;

endmodule // rtcalm_top

// ===== verification/rtcalm_peer.sv
`timescale 1ns/1ps
module rtcalm_peer (
    input wire ref_clk, // clock
    input wire pin_level, // supply switch level
    input wire active_high, // switch polarity
    input wire [7:0] wake_delay, // cycles until stable
    output wire wake_line // wake request
);
    reg [7:0] on_cnt_ff;
    wire powered = (pin_level == active_high);
    always @(posedge ref_clk) begin
        if (!powered) on_cnt_ff <= 8'h00;
        else if (on_cnt_ff != 8'hFF) on_cnt_ff <= on_cnt_ff + 8'h01;
    end
    // unpowered device lets the line fall to its pull-down
    assign wake_line = powered && (on_cnt_ff >= wake_delay);
endmodule // rtcalm_peer

// ===== verification/rtcalm_properties.sv
`timescale 1ns/1ps
module rtcalm_properties (
    input wire ref_clk, // clock
    input wire rst_n, // reset
    input wire [2:0] reg_addr, // index
    input wire [15:0] reg_wdata, // wdata
    input wire reg_wr, // write
    input wire reg_rd, // read
    input wire [15:0] reg_rdata, // rdata
    input wire sec_tick, // tick
    input wire alarm_event, // alarm
    input wire wake_event, // wake
    input wire power_ctl_signal_out, // pin
    input wire power_ctl_signal_oe // pin on
);
    reg [6:0] ctl_ff;
    wire on_ok = ctl_ff[1] & ctl_ff[2] & ctl_ff[3] & (ctl_ff[5:4] == 2'h3);
    wire pol = ctl_ff[6];
    // shadow of control bits 6:0
    always @(posedge ref_clk) begin
        if (!rst_n) ctl_ff <= 7'h00;
        else if (reg_wr && reg_addr == 3'h3) ctl_ff <= reg_wdata[6:0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("stray read data");
    AST_MTHDY_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0 |-> (reg_rdata & 16'hE0C0) == 16'h0000)
        else $error("month/day unused bits set");
    AST_WDHR_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 3'h1 |-> (reg_rdata & 16'hF8C0) == 16'h0000)
        else $error("weekday/hour unused bits set");
    AST_MINSEC_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == 3'h2 |-> (reg_rdata & 16'h8080) == 16'h0000)
        else $error("minute/second unused bits set");
    AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) > 3'h5 |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_ALARM_CAUSE: assert property (alarm_event |-> $past(sec_tick))
        else $error("alarm without second tick");
    AST_OE_GATE: assert property (power_ctl_signal_oe == on_ok)
        else $error("pin enable wrong");
    AST_IDLE_LEVEL: assert property (!power_ctl_signal_oe && $past(!power_ctl_signal_oe) |-> power_ctl_signal_out == !pol)
        else $error("idle pin level wrong");
    AST_ON_AT_ALARM: assert property (alarm_event && $past(power_ctl_signal_oe) && power_ctl_signal_oe |-> power_ctl_signal_out == pol)
        else $error("pin off at alarm");
    AST_WAKE_SAMPLED: assert property (wake_event |-> $past(power_ctl_signal_out) == pol && power_ctl_signal_out != pol)
        else $error("stray wake event");
    cover property (alarm_event && power_ctl_signal_oe);
    cover property (wake_event);
    cover property ($past(reg_rd) && $past(reg_addr) == 3'h5);
endmodule // rtcalm_properties

bind rtcalm_top rtcalm_properties u_props (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sec_tick, .alarm_event, .wake_event, .power_ctl_signal_out, .power_ctl_signal_oe);

// ===== verification/rtcalm_top_tb.sv
`timescale 1ns/1ps
module rtcalm_top_tb;
    reg ref_clk, rst_n, reg_wr, reg_rd, sec_tick, act_hi;
    reg [2:0] reg_addr;
    reg [15:0] reg_wdata;
    reg [7:0] wake_delay;
    reg [3:0] cur [0:10];
    reg [3:0] base [0:10];
    reg [15:0] umask [0:2];
    wire [15:0] reg_rdata;
    wire alarm_event, wake_event, pin_out, pin_oe, wake_in;
    integer seed, bad_count, comparisons, i, k, m, g, on_n, woke;
    integer lim [0:10];
    rtcalm_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_tick(sec_tick),
        .cur_month_tens_digit(cur[10][0]), .cur_month_ones_digit(cur[9]), .cur_day_tens_digit(cur[8][1:0]),
        .cur_day_ones_digit(cur[7]), .cur_weekday_value(cur[6][2:0]), .cur_hour_tens_digit(cur[5][1:0]),
        .cur_hour_ones_digit(cur[4]), .cur_minute_tens_digit(cur[3][2:0]), .cur_minute_ones_digit(cur[2]),
        .cur_second_tens_digit(cur[1][2:0]), .cur_second_ones_digit(cur[0]), .wake_in(wake_in),
        .alarm_event(alarm_event), .wake_event(wake_event), .power_ctl_signal_out(pin_out),
        .power_ctl_signal_oe(pin_oe));
    rtcalm_peer peer (.ref_clk(ref_clk), .pin_level(pin_oe ? pin_out : ~act_hi), .active_high(act_hi),
        .wake_delay(wake_delay), .wake_line(wake_in));
    function [15:0] pack(input integer r);
        case (r)
            0: pack = {3'h0, base[10][0], base[9], 2'h0, base[8][1:0], base[7]};
            1: pack = {5'h0, base[6][2:0], 2'h0, base[5][1:0], base[4]};
            default: pack = {1'b0, base[3][2:0], base[2], 1'b0, base[1][2:0], base[0]};
        endcase
    endfunction
    // whether field i takes part in the compare under mask m
    function integer cmp(input integer m, input integer i);
        case (m)
            2, 3, 4, 5: cmp = (i < m - 1);
            6: cmp = (i < 6);
            7: cmp = (i < 7);
            8: cmp = (i < 9) && (i != 6);
            9: cmp = (i != 6);
            default: cmp = 0;
        endcase
    endfunction
    function [15:0] ctl(input [3:0] m, input pol, input rep, input [3:0] en);
        ctl = {3'h0, 1'b1, m, rep, pol, en[3], 1'b1, en[2:0], 1'b0};
    endfunction
    task stop_test;
        begin
            $display("compared %0d, mismatched %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk_reg(input string what, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task chk_bit(input string what, input exp, input got);
        chk_reg(what, {15'h0, exp}, {15'h0, got});
    endtask
    task wr(input [2:0] a, input [15:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [15:0] exp);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1;
            chk_reg("read data", exp, reg_rdata);
        end
    endtask
    task tick(input integer pk, input exp);
        integer j;
        begin
            @(posedge ref_clk);
            for (j = 0; j < 11; j = j + 1) cur[j] <= (j == pk) ? base[j] ^ 4'h1 : base[j];
            sec_tick <= 1'b1;
            @(posedge ref_clk);
            sec_tick <= 1'b0;
            #1;
            chk_bit("alarm event", exp, alarm_event);
        end
    endtask
    task watch(input [15:0] exp_on, input exp_wake);
        begin
            on_n = 0;
            woke = 0;
            repeat (30) begin
                if (pin_out === act_hi) on_n = on_n + 1;
                if (wake_event === 1'b1) woke = 1;
                @(posedge ref_clk);
                #1;
            end
            chk_reg("pin active cycles", exp_on, on_n[15:0]);
            chk_bit("wake event", exp_wake, woke[0]);
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // run needs about 420 cycles; the 20000-cycle limit allows close to fifty times that
    initial begin
        #200000;
        bad_count = bad_count + 1;
        stop_test;
    end
    initial begin
        seed = 36;
        bad_count = 0;
        comparisons = 0;
        {rst_n, reg_wr, reg_rd, sec_tick, act_hi, reg_addr, reg_wdata} = 0;
        wake_delay = 8'h01;
        lim = '{10, 6, 10, 6, 10, 2, 6, 10, 2, 10, 2};
        umask = '{16'hE0C0, 16'hF8C0, 16'h8080};
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(3'h3, 16'h0000);
        rd(3'h4, 16'h0010);
        rd(3'h5, 16'h0000);
        rd(3'h6, 16'h0000);
        rd(3'h7, 16'h0000);
        $display("test reset values done");
        for (i = 0; i < 11; i = i + 1) base[i] = {$random(seed)} % lim[i];
        wr(3'h3, 16'h0001);
        for (i = 0; i < 3; i = i + 1) wr(i[2:0], pack(i) | umask[i]);
        wr(3'h3, 16'h0000);
        for (i = 0; i < 3; i = i + 1) wr(i[2:0], ~pack(i) & ~umask[i]);
        rd(3'h0, pack(0));
        rd(3'h1, pack(1));
        rd(3'h2, ~pack(2) & ~umask[2]);
        wr(3'h2, pack(2));
        rd(3'h2, pack(2));
        $display("test alarm registers done");
        for (m = 0; m < 11; m = m + 1) begin
            wr(3'h3, ctl(m[3:0], 1'b0, 1'b1, 4'h1));
            tick(-1, m < 10);
            k = {$random(seed)} % 11;
            tick(k, m < 10 && !cmp(m, k));
        end
        {base[10], base[9], base[8], base[7]} = 16'h0229;
        wr(3'h3, ctl(4'h9, 1'b0, 1'b1, 4'h1) | 16'h0001);
        wr(3'h0, pack(0));
        tick(-1, 1'b0);
        wr(3'h3, ctl(4'h3, 1'b0, 1'b0, 4'h1));
        tick(-1, 1'b1);
        rd(3'h5, 16'h0000);
        tick(-1, 1'b0);
        $display("test alarm masks done");
        wr(3'h4, 16'h0008);
        for (g = 0; g < 4; g = g + 1) begin
            act_hi <= g[0];
            wake_delay <= g[1] ? 8'h28 : 8'h01;
            wr(3'h3, ctl(4'h3, g[0], 1'b1, 4'hF));
            tick(-1, 1'b1);
            watch(16'h000A, !g[1]);
        end
        rd(3'h5, 16'h000C);
        wr(3'h5, 16'h0004);
        rd(3'h5, 16'h0008);
        $display("test power cycle done");
        for (g = 0; g < 4; g = g + 1) begin
            wr(3'h3, ctl(4'h3, 1'b1, 1'b1, 4'hF ^ (4'h1 << g)));
            #1;
            chk_bit("pin enable", 1'b0, pin_oe);
            tick(-1, g != 0);
            watch(16'h0000, 1'b0);
        end
        $display("test power gating done");
        stop_test;
    end
endmodule // rtcalm_top_tb
